//--- hw/csbu_cfg.svh
/*
 holds the timing counts, field widths, step sizes and status flag positions
 used by the conditional skip/branch unit. assumes nothing but inclusion.
*/
`ifndef CSBU_CFG_SVH
`define CSBU_CFG_SVH
`define CSBU_PC_W 16
`define CSBU_K_W 7
`define CSBU_FLAG_C 3'h0
`define CSBU_FLAG_Z 3'h1
`define CSBU_FLAG_N 3'h2
`define CSBU_FLAG_V 3'h3
`define CSBU_FLAG_H 3'h5
`define CSBU_STEP_NORMAL 2'h1
`define CSBU_STEP_SKIP1 2'h2
`define CSBU_STEP_SKIP2 2'h3
`define CSBU_CYC_NOT_TAKEN 2'h1
`define CSBU_CYC_TAKEN 2'h2
`define CSBU_CYC_SKIP2 2'h3
`endif

//--- hw/csbu_pkg.sv
/*
 types for the conditional skip/branch unit. assumes csbu_cfg.svh.
*/
`include "csbu_cfg.svh"
package csbu_pkg;
   typedef enum logic [4:0] {
      CSBU_OP_NONE,
      CSBU_OP_SKIP_IF_REG_BIT_CLEAR,
      CSBU_OP_SKIP_IF_REG_BIT_SET,
      CSBU_OP_SKIP_IF_IO_BIT_CLEAR,
      CSBU_OP_SKIP_IF_IO_BIT_SET,
      CSBU_OP_BRANCH_IF_FLAG_SET,
      CSBU_OP_BRANCH_IF_FLAG_CLEAR,
      CSBU_OP_BRANCH_IF_EQUAL,
      CSBU_OP_BRANCH_IF_NOT_EQUAL,
      CSBU_OP_BRANCH_IF_CARRY_SET,
      CSBU_OP_BRANCH_IF_LOWER,
      CSBU_OP_BRANCH_IF_CARRY_CLEAR,
      CSBU_OP_BRANCH_IF_SAME_OR_HIGHER,
      CSBU_OP_BRANCH_IF_MINUS,
      CSBU_OP_BRANCH_IF_PLUS,
      CSBU_OP_BRANCH_IF_GE_SIGNED,
      CSBU_OP_BRANCH_IF_LT_SIGNED,
      CSBU_OP_BRANCH_IF_HALF_CARRY_SET
   } csbu_op_e;
   typedef logic [`CSBU_PC_W-1:0] csbu_pc_t;
endpackage

//--- hw/csbu_cond.sv
/*
 combinational condition evaluator: decides whether the tested
 condition of an operation holds. assumes operands are stable.
*/
`timescale 1ns/1ps
`default_nettype none
module csbu_cond
   import csbu_pkg::*;
(
   input wire csbu_pkg::csbu_op_e op, // operation
   input wire logic [7:0] operand, // gp or io register value
   input wire logic [2:0] bit_sel, // bit under test
   input wire logic [7:0] status_register, // flags, read only
   output logic cond_true, // condition holds
   output logic is_skip // operation is a skip
);
   logic tb;
   logic sb;
   always_comb begin
      tb = operand[bit_sel];
      sb = status_register[bit_sel];
      is_skip = 1'b0;
      cond_true = 1'b0;
      case (op)
         CSBU_OP_SKIP_IF_REG_BIT_CLEAR: begin is_skip = 1'b1; cond_true = ~tb; end
         CSBU_OP_SKIP_IF_REG_BIT_SET: begin is_skip = 1'b1; cond_true = tb; end
         CSBU_OP_SKIP_IF_IO_BIT_CLEAR: begin is_skip = 1'b1; cond_true = ~tb; end
         CSBU_OP_SKIP_IF_IO_BIT_SET: begin is_skip = 1'b1; cond_true = tb; end
         CSBU_OP_BRANCH_IF_FLAG_SET: cond_true = sb;
         CSBU_OP_BRANCH_IF_FLAG_CLEAR: cond_true = ~sb;
         CSBU_OP_BRANCH_IF_EQUAL: cond_true = status_register[`CSBU_FLAG_Z];
         CSBU_OP_BRANCH_IF_NOT_EQUAL: cond_true = ~status_register[`CSBU_FLAG_Z];
         CSBU_OP_BRANCH_IF_CARRY_SET,
         CSBU_OP_BRANCH_IF_LOWER: cond_true = status_register[`CSBU_FLAG_C];
         CSBU_OP_BRANCH_IF_CARRY_CLEAR,
         CSBU_OP_BRANCH_IF_SAME_OR_HIGHER: cond_true = ~status_register[`CSBU_FLAG_C];
         CSBU_OP_BRANCH_IF_MINUS: cond_true = status_register[`CSBU_FLAG_N];
         CSBU_OP_BRANCH_IF_PLUS: cond_true = ~status_register[`CSBU_FLAG_N];
         CSBU_OP_BRANCH_IF_GE_SIGNED:
            cond_true = ~(status_register[`CSBU_FLAG_N] ^ status_register[`CSBU_FLAG_V]);
         CSBU_OP_BRANCH_IF_LT_SIGNED:
            cond_true = status_register[`CSBU_FLAG_N] ^ status_register[`CSBU_FLAG_V];
         CSBU_OP_BRANCH_IF_HALF_CARRY_SET: cond_true = status_register[`CSBU_FLAG_H];
         default: cond_true = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

//--- hw/csbu_target.sv
/*
 combinational next program counter arithmetic. assumes pc wraps.
*/
`timescale 1ns/1ps
`default_nettype none
module csbu_target
   import csbu_pkg::*;
(
   input wire csbu_pkg::csbu_pc_t program_counter, // current pc
   input wire logic [`CSBU_K_W-1:0] k_offset, // signed word offset
   input wire logic [1:0] step, // sequential advance
   output csbu_pkg::csbu_pc_t seq_pc, // pc + step
   output csbu_pkg::csbu_pc_t branch_pc // pc + k + 1
);
   csbu_pc_t k_ext;
   always_comb begin
      // sign extension keeps backward branches correct across the pc width
      k_ext = {{(`CSBU_PC_W-`CSBU_K_W){k_offset[`CSBU_K_W-1]}}, k_offset};
      seq_pc = program_counter + {{(`CSBU_PC_W-2){1'b0}}, step};
      branch_pc = program_counter + k_ext + {{(`CSBU_PC_W-1){1'b0}}, 1'b1};
   end
endmodule
`default_nettype wire

//--- hw/csbu_top.sv
/*
 conditional skip/branch unit: one request per cycle, registered result
 next cycle. assumes the core supplies operands and the word length of
 the following instruction in the same cycle as the request.
*/
`timescale 1ns/1ps
`default_nettype none
module csbu_top
   import csbu_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic srst, // sync reset, high
   input wire logic req_valid, // request strobe
   input wire csbu_pkg::csbu_op_e op, // operation
   input wire csbu_pkg::csbu_pc_t program_counter, // pc of this op
   input wire logic [7:0] operand, // gp or io register value
   input wire logic [2:0] bit_sel, // b or s field
   input wire logic [`CSBU_K_W-1:0] k_offset, // branch offset
   input wire logic next_is_two_word, // following op is two words
   input wire logic [7:0] status_register, // flags in
   output logic res_valid, // result pulse
   output csbu_pkg::csbu_pc_t next_pc, // new pc
   output logic taken, // skip or branch taken
   output logic [1:0] cycles, // cycles used
   output logic [7:0] status_out // flags out, unchanged
);
   import csbu_pkg::*;
   logic cond_true;
   logic is_skip;
   logic [1:0] step;
   csbu_pc_t seq_pc;
   csbu_pc_t branch_pc;
   logic res_valid_d, res_valid_q;
   logic taken_d, taken_q;
   logic [1:0] cycles_d, cycles_q;
   csbu_pc_t next_pc_d, next_pc_q;
   logic [7:0] status_d, status_q;

   csbu_cond u_cond (
      .op(op),
      .operand(operand),
      .bit_sel(bit_sel),
      .status_register(status_register),
      .cond_true(cond_true),
      .is_skip(is_skip)
   );

   csbu_target u_target (
      .program_counter(program_counter),
      .k_offset(k_offset),
      .step(step),
      .seq_pc(seq_pc),
      .branch_pc(branch_pc)
   );

   always_comb begin
      step = `CSBU_STEP_NORMAL;
      if (is_skip && cond_true) begin
         step = next_is_two_word ? `CSBU_STEP_SKIP2 : `CSBU_STEP_SKIP1;
      end
   end

   always_comb begin
      res_valid_d = req_valid && (op != CSBU_OP_NONE);
      taken_d = taken_q;
      cycles_d = cycles_q;
      next_pc_d = next_pc_q;
      // flags pass through the register unchanged; only srst writes them, to zero
      status_d = status_register;
      if (res_valid_d) begin
         taken_d = cond_true;
         if (is_skip) begin
            next_pc_d = seq_pc;
            if (!cond_true) begin
               cycles_d = `CSBU_CYC_NOT_TAKEN;
            end else if (next_is_two_word) begin
               cycles_d = `CSBU_CYC_SKIP2;
            end else begin
               cycles_d = `CSBU_CYC_TAKEN;
            end
         end else begin
            next_pc_d = cond_true ? branch_pc : seq_pc;
            cycles_d = cond_true ? `CSBU_CYC_TAKEN : `CSBU_CYC_NOT_TAKEN;
         end
      end
      if (srst) begin
         res_valid_d = 1'b0;
         taken_d = 1'b0;
         cycles_d = 2'h0;
         next_pc_d = '0;
         status_d = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      res_valid_q <= res_valid_d;
      taken_q <= taken_d;
      cycles_q <= cycles_d;
      next_pc_q <= next_pc_d;
      status_q <= status_d;
   end

   assign res_valid = res_valid_q;
   assign taken = taken_q;
   assign cycles = cycles_q;
   assign next_pc = next_pc_q;
   assign status_out = status_q;
endmodule
`default_nettype wire

//--- tb/csbu_asserts.sv
/* checker for csbu_top. sees only the top ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
`include "csbu_cfg.svh"
module csbu_asserts
   import csbu_pkg::*;
(
   input wire logic clk, // clock
   input wire logic srst, // reset
   input wire logic req_valid, // request
   input wire csbu_pkg::csbu_op_e op, // op
   input wire csbu_pkg::csbu_pc_t program_counter, // pc
   input wire logic [7:0] operand, // reg value
   input wire logic [2:0] bit_sel, // b or s
   input wire logic [`CSBU_K_W-1:0] k_offset, // offset
   input wire logic next_is_two_word, // long next op
   input wire logic [7:0] status_register, // flags in
   input wire logic res_valid, // result
   input wire csbu_pkg::csbu_pc_t next_pc, // new pc
   input wire logic taken, // taken
   input wire logic [1:0] cycles, // cycle count
   input wire logic [7:0] status_out // flags out
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [7:0] sr_q;
   wire logic acc = req_valid && op != CSBU_OP_NONE;
   wire logic skp = acc && op <= CSBU_OP_SKIP_IF_IO_BIT_SET;
   always_ff @(posedge clk) begin
      sr_q <= status_register;
   end
   a_answer_next: assert property (acc |=> res_valid) else $error("no result");
   a_none_quiet: assert property (!acc |=> !res_valid) else $error("stray result");
   a_flags_kept: assert property (!$past(srst) |-> status_out == sr_q) else $error("flags changed");
   a_not_taken: assert property (acc ##1 !taken |-> next_pc == $past(program_counter) + 16'h1
      && cycles == 2'h1) else $error("bad step");
   a_skip_step: assert property (skp ##1 taken |-> cycles == ($past(next_is_two_word) ? 2'h3 : 2'h2)
      && next_pc == $past(program_counter) + ($past(next_is_two_word) ? 16'h3 : 16'h2)) else $error("bad skip");
   a_branch_target: assert property (acc && !skp ##1 taken |-> cycles == 2'h2
      && next_pc == $past(program_counter) + csbu_pc_t'($signed($past(k_offset))) + 16'h1) else $error("bad target");
   a_equal_cond: assert property (acc && op == CSBU_OP_BRANCH_IF_EQUAL |=> taken == sr_q[1])
      else $error("bad equal");
   a_ge_cond: assert property (acc && op == CSBU_OP_BRANCH_IF_GE_SIGNED |=> taken == !(sr_q[2] ^ sr_q[3]))
      else $error("bad ge");
   c_long_skip: cover property (skp ##1 taken && cycles == 2'h3);
   c_branch: cover property (acc && !skp ##1 taken);
   c_fall: cover property (acc ##1 !taken);
endmodule
bind csbu_top csbu_asserts csbu_asserts_i (.clk, .srst, .req_valid, .op, .program_counter, .operand, .bit_sel,
   .k_offset, .next_is_two_word, .status_register, .res_valid, .next_pc, .taken, .cycles, .status_out);
`default_nettype wire

//--- tb/tb_top.sv
/* bench for csbu_top. drives ports on falling edges, no partner. */
`timescale 1ns/1ps
`default_nettype none
`include "csbu_cfg.svh"
module tb_top;
   import csbu_pkg::*;
   logic clk, srst, req_valid, next_is_two_word, res_valid, taken;
   csbu_op_e op;
   csbu_pc_t program_counter, next_pc;
   logic [7:0] operand, status_register, status_out;
   logic [2:0] bit_sel;
   logic [`CSBU_K_W-1:0] k_offset;
   logic [1:0] cycles;
   int miscompares = 0;
   int cmp_count = 0;
   csbu_top csbu_top_i (.clk, .srst, .req_valid, .op, .program_counter, .operand, .bit_sel,
      .k_offset, .next_is_two_word, .status_register, .res_valid, .next_pc, .taken, .cycles, .status_out);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic want(csbu_op_e o, logic [7:0] d, logic [2:0] b, logic [7:0] s);
      case (o)
         CSBU_OP_SKIP_IF_REG_BIT_CLEAR, CSBU_OP_SKIP_IF_IO_BIT_CLEAR: return !d[b];
         CSBU_OP_SKIP_IF_REG_BIT_SET, CSBU_OP_SKIP_IF_IO_BIT_SET: return d[b];
         CSBU_OP_BRANCH_IF_FLAG_SET: return s[b];
         CSBU_OP_BRANCH_IF_FLAG_CLEAR: return !s[b];
         CSBU_OP_BRANCH_IF_EQUAL: return s[1];
         CSBU_OP_BRANCH_IF_NOT_EQUAL: return !s[1];
         CSBU_OP_BRANCH_IF_CARRY_SET, CSBU_OP_BRANCH_IF_LOWER: return s[0];
         CSBU_OP_BRANCH_IF_CARRY_CLEAR, CSBU_OP_BRANCH_IF_SAME_OR_HIGHER: return !s[0];
         CSBU_OP_BRANCH_IF_MINUS: return s[2];
         CSBU_OP_BRANCH_IF_PLUS: return !s[2];
         CSBU_OP_BRANCH_IF_GE_SIGNED: return !(s[2] ^ s[3]);
         CSBU_OP_BRANCH_IF_LT_SIGNED: return s[2] ^ s[3];
         CSBU_OP_BRANCH_IF_HALF_CARRY_SET: return s[5];
         default: return 1'b0;
      endcase
   endfunction
   task automatic do_op(csbu_op_e o, csbu_pc_t pc, logic [7:0] d, logic [2:0] b, logic [6:0] k, logic tw,
         logic [7:0] s);
      logic t;
      logic sk;
      @(negedge clk);
      op = o;
      program_counter = pc;
      operand = d;
      bit_sel = b;
      k_offset = k;
      next_is_two_word = tw;
      status_register = s;
      req_valid = 1'b1;
      t = want(o, d, b, s);
      sk = o <= CSBU_OP_SKIP_IF_IO_BIT_SET;
      @(negedge clk);
      req_valid = 1'b0;
      chk("res_valid", res_valid, 16'h1);
      chk("taken", taken, t);
      chk("taken_h", taken, t);
      chk("next_pc", next_pc,
         !t ? pc + 16'h1 : sk ? pc + (tw ? 16'h3 : 16'h2) : pc + csbu_pc_t'($signed(k)) + 16'h1);
      chk("cycles", cycles, !t ? 16'h1 : sk && tw ? 16'h3 : 16'h2);
      chk("status_out", status_out, s);
   endtask
   task automatic t_skips;
      for (int b = 0; b < 16; b++)
         for (int i = 1; i < 5; i++)
            do_op(csbu_op_e'(i), 16'h1230, 8'h5a, b[2:0], 7'h0, b[3], 8'hff);
      $display("t_skips done");
   endtask
   task automatic t_branches;
      for (int v = 0; v < 64; v++)
         for (int i = 5; i < 18; i++)
            do_op(csbu_op_e'(i), 16'h0400, 8'h00, v[2:0], v[0] ? 7'h40 : 7'h3f, 1'b0,
               {2'b00, v[4], 1'b0, v[3:0]} | (8'h01 << v[5:3]));
      $display("t_branches done");
   endtask
   task automatic t_edges;
      do_op(CSBU_OP_BRANCH_IF_NOT_EQUAL, 16'hffff, 8'h00, 3'h0, 7'h01, 1'b0, 8'h00);
      @(negedge clk);
      req_valid = 1'b1;
      op = CSBU_OP_NONE;
      @(negedge clk);
      req_valid = 1'b0;
      chk("res_valid", res_valid, 16'h0);
      $display("t_edges done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {srst, req_valid, next_is_two_word, program_counter, operand, status_register, bit_sel, k_offset} = '0;
      op = CSBU_OP_NONE;
      srst = 1'b1;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      t_skips();
      t_branches();
      t_edges();
      end_of_test();
   end
   initial begin
      // about 900 ops of two cycles each
      repeat (6000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
